// file: hdl/tick_timer_params.svh
// register map, field positions and timing counts of the tick timer
//
// Functional notes
// R1 - timer mode (clock source select 0) counts every instruction cycle
// R2 - a tick count write blocks counting for the next two instruction cycles
// R3 - counter mode counts selected edges of pin or sensing oscillator
// R4 - source select 1 with external select 0 counts pin edges
// R5 - source select 1 with external select 1 counts oscillator edges
// R6 - edge select bit picks rising or falling edges of either source
// R7 - clearing the bypass bit routes the count source through the prescaler
// R8 - eight prescale ratios 1:2 up to 1:256 from a 3-bit field
// R9 - rate code n divides by two to the power n plus one
// R10 - ratio 1:1 only while the prescaler bypass bit is set
// R11 - prescaler unreachable by software, cleared by every tick count write
// R12 - wrap from FFh to 00h is an overflow event, enable gates the interrupt; the status bit with its mask bit also raises irq, ungated by the enable
// R13 - overflow flag set on every wrap regardless of the enable bit
// R14 - only software clears the overflow flag
// R15 - interrupt request high while flag and enable are both set
// R16 - counter mode increments are sampled in the Q2 and Q4 phases
// R17 - during sleep counting stops and the tick count holds
// R18 - overflow cannot wake from sleep since the counter is frozen
// R19 - dedicated 8-bit prescaler, separate from the watchdog prescaler
`ifndef TICK_TIMER_PARAMS_SVH
`define TICK_TIMER_PARAMS_SVH

`define ADDR_TICK 8'h00
`define ADDR_OPT 8'h04
`define ADDR_IRQC 8'h08
`define ADDR_STS 8'h0C
`define ADDR_MASK 8'h10
`define ADDR_CAPS 8'h14

`define OPT_CS_BIT 5
`define OPT_SE_BIT 4
`define OPT_PSA_BIT 3
`define OPT_RATE_HI 2
`define OPT_RATE_LO 0
`define OPT_RST 6'h3F

`define IRQC_EN_BIT 5
`define IRQC_FLAG_BIT 2
`define STS_OVF_BIT 0
`define MASK_OVF_BIT 0
`define CAPS_XCS_BIT 0

`define PHASE_Q2 2'h1
`define PHASE_Q4 2'h3
`define PHASE_STEP 2'h1
`define INHIBIT_CYC 2'h2
`define INHIBIT_STEP 2'h1
`define TICK_MAX 8'hFF
`define TICK_STEP 8'h01
`define PSC_BASE 8'h02
`define PSC_STEP 8'h01

`endif

// file: hdl/tick_timer_pkg.sv
// types shared by the tick timer
package tick_timer_pkg;
  typedef enum logic [1:0] {SRC_INSTR, SRC_PIN, SRC_CAP} src_t;
endpackage

// file: hdl/eight_bit_timer_counter.sv
// 8-bit timer/counter with prescaler, avalon-mm registers and interrupt
`include "tick_timer_params.svh"

module eight_bit_timer_counter
  import tick_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_clk_pin,
  input wire logic cap_sense_osc_clk,
  input wire logic sleep,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state on every access

  logic ack_r;
  logic req;
  logic wr_acc;
  logic rd_acc;
  logic wr_tick;
  logic wr_opt;
  logic wr_irqc;
  logic wr_mask;
  logic wr_caps;
  logic rd_sts;
  logic [31:0] rd_mux;
  logic [31:0] readdata_r;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_acc = avs_write & ack_r & avs_byteenable[0];
  assign rd_acc = avs_read & ack_r;
  assign wr_tick = wr_acc && (avs_address == `ADDR_TICK);
  assign wr_opt = wr_acc && (avs_address == `ADDR_OPT);
  assign wr_irqc = wr_acc && (avs_address == `ADDR_IRQC);
  assign wr_mask = wr_acc && (avs_address == `ADDR_MASK);
  assign wr_caps = wr_acc && (avs_address == `ADDR_CAPS);
  assign rd_sts = rd_acc && (avs_address == `ADDR_STS);
  assign avs_readdata = readdata_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-visible control bits

  logic [5:0] opt_r;
  logic ovf_irq_en;
  logic ovf_flag;
  logic ext_src_sel;
  logic sts_r;
  logic mask_r;
  logic clk_src_sel;
  logic src_edge_sel;
  logic prescale_bypass;
  logic [2:0] prescale_rate;
  logic ovf_evt;

  assign clk_src_sel = opt_r[`OPT_CS_BIT];
  assign src_edge_sel = opt_r[`OPT_SE_BIT];
  assign prescale_bypass = opt_r[`OPT_PSA_BIT];
  assign prescale_rate = opt_r[`OPT_RATE_HI:`OPT_RATE_LO];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opt_r <= `OPT_RST;
    end else if (wr_opt) begin
      opt_r <= avs_writedata[5:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_irq_en <= 1'b0;
      mask_r <= 1'b0;
      ext_src_sel <= 1'b0;
    end else begin
      if (wr_irqc) begin
        ovf_irq_en <= avs_writedata[`IRQC_EN_BIT];
      end
      if (wr_mask) begin
        mask_r <= avs_writedata[`MASK_OVF_BIT];
      end
      if (wr_caps) begin
        ext_src_sel <= avs_writedata[`CAPS_XCS_BIT];
      end
    end
  end

  // hardware only sets; a wrap in the clearing cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_flag <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag <= 1'b1; // R13
    end else if (wr_irqc) begin
      ovf_flag <= avs_writedata[`IRQC_FLAG_BIT]; // R14
    end
  end

  // only the bit that was returned is cleared, so a late event survives
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sts_r <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~(rd_sts & readdata_r[`STS_OVF_BIT])) | ovf_evt;
    end
  end

  assign irq = (ovf_flag & ovf_irq_en) | (sts_r & mask_r); // R12 R15

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle phases: one system clock each, four per cycle

  logic [1:0] phase_r;
  logic q4;
  logic sample;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + `PHASE_STEP;
    end
  end

  assign q4 = phase_r == `PHASE_Q4;
  assign sample = (phase_r == `PHASE_Q2) | q4; // R16

  ////////////////////////////////////////////////////////////////////////////
  // count source selection and edge detection

  src_t src;
  logic sel_lvl;
  logic sel_prev_r;
  logic ext_edge;
  logic src_pulse;

  always_comb begin
    if (!clk_src_sel) begin
      src = SRC_INSTR; // R1
    end else if (ext_src_sel) begin
      src = SRC_CAP; // R5
    end else begin
      src = SRC_PIN; // R4
    end
  end

  always_comb begin
    case (src)
      SRC_PIN: sel_lvl = ext_clk_pin;
      SRC_CAP: sel_lvl = cap_sense_osc_clk;
      default: sel_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_prev_r <= 1'b0;
    end else begin
      sel_prev_r <= sel_lvl;
    end
  end

  // edge select 1 counts high-to-low, 0 counts low-to-high
  assign ext_edge = src_edge_sel ? (sel_prev_r & ~sel_lvl)
                                 : (~sel_prev_r & sel_lvl); // R6

  // no count source pulse passes in sleep, so no overflow can arise to wake the core
  always_comb begin
    case (src)
      SRC_INSTR: src_pulse = q4 & ~sleep; // R1 R18
      default: src_pulse = ext_edge & ~sleep; // R3 R17
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: private to this counter, never on the bus

  logic [7:0] psc_r;
  logic [7:0] psc_mask;
  logic psc_full;
  logic inc_pulse;

  assign psc_mask = 8'((`PSC_BASE << prescale_rate) - `PSC_STEP); // R8 R9
  assign psc_full = (psc_r & psc_mask) == psc_mask;
  assign inc_pulse = src_pulse & (prescale_bypass | psc_full); // R7 R10

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      psc_r <= 8'h00;
    end else if (wr_tick) begin
      psc_r <= 8'h00; // R11
    end else if (src_pulse & ~prescale_bypass) begin
      psc_r <= psc_r + `PSC_STEP; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisation, write inhibit and the tick count

  logic pend_r;
  logic [1:0] inhib_r;
  logic [7:0] tick_count;
  logic take;

  // an increment waits for the next Q2 or Q4 sample
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
    end else if (wr_tick) begin
      pend_r <= 1'b0;
    end else if (!sleep) begin
      pend_r <= ~sample & (pend_r | inc_pulse); // R16
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inhib_r <= 2'h0;
    end else if (wr_tick) begin
      inhib_r <= `INHIBIT_CYC; // R2
    end else if (q4 && inhib_r != 2'h0) begin
      inhib_r <= inhib_r - `INHIBIT_STEP;
    end
  end

  // an increment sampled while inhibited is dropped, as the hardware does
  assign take = ~sleep & sample & (pend_r | inc_pulse) & ~wr_tick
                & (inhib_r == 2'h0); // R2 R17
  assign ovf_evt = take & (tick_count == `TICK_MAX); // R12

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_count <= 8'h00;
    end else if (wr_tick) begin
      tick_count <= avs_writedata[7:0];
    end else if (take) begin
      tick_count <= tick_count + `TICK_STEP; // R1 R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the wait cycle

  always_comb begin
    case (avs_address)
      `ADDR_TICK: rd_mux = 32'(tick_count);
      `ADDR_OPT: rd_mux = 32'(opt_r);
      `ADDR_IRQC: rd_mux = 32'({ovf_irq_en, 2'b00, ovf_flag, 2'b00});
      `ADDR_STS: rd_mux = 32'(sts_r);
      `ADDR_MASK: rd_mux = 32'(mask_r);
      `ADDR_CAPS: rd_mux = 32'(ext_src_sel);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      readdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_tick_write;
    wr_tick;
  endsequence

  sequence s_quiet_q4;
    !clk_src_sel && prescale_bypass && !sleep && q4
      && inhib_r == 2'h0 && !wr_tick;
  endsequence

  chk_timer_step: assert property ( // R1
    s_quiet_q4 |=> tick_count == 8'($past(tick_count) + 8'h01))
    else $error("timer mode missed an instruction cycle");

  chk_write_inhibit: assert property ( // R2
    s_tick_write ##1 (!wr_tick)[*4] |-> $stable(tick_count))
    else $error("tick count moved during write inhibit");

  chk_psc_clear: assert property ( // R11
    s_tick_write |=> psc_r == 8'h00 && !pend_r)
    else $error("prescaler not cleared by tick write");

  chk_sample_phase: assert property ( // R16
    !$past(wr_tick) && tick_count != $past(tick_count)
      |-> $past(phase_r) == `PHASE_Q2 || $past(phase_r) == `PHASE_Q4)
    else $error("increment outside Q2 and Q4");

  chk_sleep_hold: assert property ( // R17
    sleep && !wr_tick |=> $stable(tick_count))
    else $error("tick count changed in sleep");

  chk_wrap_flag: assert property ( // R13
    take && tick_count == 8'hFF |=> tick_count == 8'h00 && ovf_flag
      && sts_r)
    else $error("wrap did not raise the overflow flag");

  chk_flag_sw_clear: assert property ( // R14
    $fell(ovf_flag) |-> $past(wr_irqc))
    else $error("overflow flag cleared without software");

  chk_irq_gate: assert property ( // R15
    ovf_flag && ovf_irq_en |-> irq ##1 (irq || !ovf_flag || !ovf_irq_en))
    else $error("interrupt request not raised");

  chk_psc_ratio: assert property ( // R9
    inc_pulse && !prescale_bypass
      |-> (psc_r & psc_mask) == psc_mask && psc_mask[0])
    else $error("prescaler output at wrong ratio");

  chk_bypass_pass: assert property ( // R10
    src_pulse && prescale_bypass |-> inc_pulse)
    else $error("bypass did not pass every source edge");

  chk_pin_source: assert property ( // R4
    clk_src_sel && !ext_src_sel && !sleep && !prescale_bypass
      && ($rose(ext_clk_pin) && !src_edge_sel
      || $fell(ext_clk_pin) && src_edge_sel) && !wr_tick
      |=> psc_r == 8'($past(psc_r) + 8'h01))
    else $error("pin edge not counted by prescaler");

  chk_wait_state: assert property (
    req && !ack_r |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");

  chk_psc_sleep: assert property ( // R17
    sleep && !wr_tick |=> $stable(psc_r))
    else $error("prescaler moved in sleep");

  chk_cap_source: assert property ( // R5
    clk_src_sel && ext_src_sel && !sleep
      && ($rose(cap_sense_osc_clk) && !src_edge_sel
      || $fell(cap_sense_osc_clk) && src_edge_sel)
      |-> src_pulse)
    else $error("oscillator edge not taken as count source");

  chk_edge_polarity: assert property ( // R6
    clk_src_sel && !ext_src_sel
      && ($fell(ext_clk_pin) && !src_edge_sel
      || $rose(ext_clk_pin) && src_edge_sel)
      |-> !src_pulse)
    else $error("pin edge of the wrong polarity counted");

  chk_sts_sticky: assert property ( // R12
    sts_r && !rd_sts |=> sts_r)
    else $error("overflow status lost without a read");

  chk_irq_quiet: assert property ( // R15
    !(ovf_flag && ovf_irq_en) && !(sts_r && mask_r) |-> !irq)
    else $error("interrupt request without a pending cause");

endmodule

// file: tb/edge_source_model.sv
// stand-in for the external count pin and the sensing oscillator
module edge_source_model (
  input wire logic sys_clk,
  output logic ext_clk_pin,
  output logic cap_sense_osc_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ext_clk_pin = 1'b0;
    cap_sense_osc_clk = 1'b0;
  end

  //////////////////////////////////////////////////////////////
  // lines parked low between bursts, so a stale level never counts
  task automatic park();
    @(posedge sys_clk);
    ext_clk_pin <= 1'b0;
    cap_sense_osc_clk <= 1'b0;
  endtask

  // np rises on the pin and no on the oscillator, one fall fewer each;
  // both lines run at once, so the unselected one is live noise
  task automatic burst(input int np, input int no);
    for (int i = 0; i < 2 * np - 1 || i < 2 * no - 1; i++) begin
      repeat (4) @(posedge sys_clk);
      if (i < 2 * np - 1) begin
        ext_clk_pin <= ~ext_clk_pin;
      end
      if (i < 2 * no - 1) begin
        cap_sense_osc_clk <= ~cap_sense_osc_clk;
      end
    end
  endtask
endmodule

// file: tb/tb_eight_bit_timer_counter.sv
// self-checking bench for the 8-bit timer/counter
`include "tick_timer_params.svh"

module tb_eight_bit_timer_counter
  import tick_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, sleep, irq;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd_data;
  logic ext_clk_pin, cap_sense_osc_clk;
  int num_errors = 0;
  int checks = 0;

  eight_bit_timer_counter i_eight_bit_timer_counter (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_clk_pin(ext_clk_pin), .cap_sense_osc_clk(cap_sense_osc_clk),
    .sleep(sleep), .irq(irq)
  );

  edge_source_model i_edge_source_model (
    .sys_clk(sys_clk), .ext_clk_pin(ext_clk_pin),
    .cap_sense_osc_clk(cap_sense_osc_clk)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // irq follows the registers, so let the write edge land first
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // pre-edge values are what the master samples at each edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    rd_data = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(rd_data, exp);
  endtask

  // capture points k+3 cycles apart; multiples of 4 hide the phase
  task automatic rate(input int k, input logic [7:0] exp);
    logic [7:0] t;
    bus(1'b0, `ADDR_TICK, 32'h0, 4'hF);
    t = rd_data[7:0];
    repeat (k) @(posedge sys_clk);
    bus(1'b0, `ADDR_TICK, 32'h0, 4'hF);
    chk({24'h0, rd_data[7:0] - t}, {24'h0, exp});
  endtask

  //////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    sleep = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(`ADDR_OPT, 32'h3F);
    rdc(`ADDR_TICK, 32'h0);
    rdc(`ADDR_IRQC, 32'h0);
    rdc(8'h1C, 32'h0);
    bus(1'b1, `ADDR_OPT, 32'h08, 4'h0);
    rdc(`ADDR_OPT, 32'h3F);
    wr(`ADDR_OPT, 32'h08);
    wr(`ADDR_TICK, 32'hFE);
    repeat (6) @(posedge sys_clk);
    rdc(`ADDR_TICK, 32'hFE);
    rate(37, 8'd10);
    rdc(`ADDR_IRQC, 32'h04);
    rdc(`ADDR_STS, 32'h1);
    wr(`ADDR_IRQC, 32'h0);
    wr(`ADDR_TICK, 32'hFE);
    repeat (20) @(posedge sys_clk);
    rdc(`ADDR_IRQC, 32'h04);
    chk_irq(1'b0);
    wr(`ADDR_MASK, 32'h1);
    chk_irq(1'b1);
    rdc(`ADDR_STS, 32'h1);
    chk_irq(1'b0);
    rdc(`ADDR_STS, 32'h0);
    wr(`ADDR_MASK, 32'h0);
    wr(`ADDR_IRQC, 32'h24);
    chk_irq(1'b1);
    rdc(`ADDR_IRQC, 32'h24);
    wr(`ADDR_IRQC, 32'h20);
    chk_irq(1'b0);
    wr(`ADDR_TICK, 32'hFF);
    sleep <= 1'b1;
    rate(37, 8'd0);
    chk_irq(1'b0);
    rdc(`ADDR_IRQC, 32'h20);
    sleep <= 1'b0;
    wr(`ADDR_IRQC, 32'h0);
    for (int n = 0; n < 8; n++) begin
      wr(`ADDR_OPT, n);
      wr(`ADDR_TICK, 32'h0);
      repeat (16 << n) @(posedge sys_clk);
      rate((16 << n) - 3, 8'd2);
    end
    for (int c = 0; c < 6; c++) begin
      // c[0] falling edges, c[1] oscillator, c[2] prescaler at 1:2
      i_edge_source_model.park();
      wr(`ADDR_CAPS, c[1]);
      wr(`ADDR_OPT, {26'h0, 1'b1, c[0], ~c[2], 3'h0});
      repeat (8) @(posedge sys_clk);
      wr(`ADDR_TICK, 32'h0);
      repeat (12) @(posedge sys_clk);
      i_edge_source_model.burst(5, 3);
      repeat (12) @(posedge sys_clk);
      rdc(`ADDR_TICK, ((c[1] ? 3 : 5) - c[0]) >> c[2]);
    end
    wrap_up();
  end
endmodule
